// *** include/pamc_pkg.sv ***
// Purpose: Shared constants and carriers for the PHY negotiation and mode control block
// Assumes: 100 MHz system clock, 16-bit management registers on a plain strobe port
// Notes:   Ability vectors are ordered {100 full, 100 half, 10 full, 10 half}
`default_nettype none
package pamc_pkg;
  // Clock rate and printed or chosen times in their own units
  localparam int CLK_KHZ        = 100000;
  localparam int LINK_FAIL_MS   = 1200;   // Least no-pulse window before link fail
  localparam int HW_RST_MS      = 10;     // Least hold time of the reset pin
  localparam int XOVER_MS       = 50;     // Silence on the receive pair before a swap
  localparam int BLINK_MS       = 40;     // Half period of indicator blinking

  // Register offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADV    = 5'h04;
  localparam logic [4:0] REG_SPEC   = 5'h10;
  localparam logic [4:0] REG_INT    = 5'h11;

  // Control register fields
  localparam int CTRL_SOFT_RST  = 15;
  localparam int CTRL_SPEED     = 13;
  localparam int CTRL_AN_EN     = 12;
  localparam int CTRL_PWR_DOWN  = 11;
  localparam int CTRL_RESTART   = 9;
  localparam int CTRL_DUPLEX    = 8;
  // Advertisement register fields
  localparam int ADV_PAUSE      = 10;
  localparam int ADV_ABIL_LSB   = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  // Specific register fields
  localparam int SPEC_XOVER_OFF = 11;
  localparam int SPEC_REPEATER  = 2;
  localparam int SPEC_APS       = 1;
  localparam int SPEC_ANA_OFF   = 0;
  // Interrupt register fields: flags low, enables high
  localparam int INT_FLAG_LSB   = 0;
  localparam int INT_MASK_LSB   = 8;
  // Cause order in the flag vector
  localparam int EV_DUPLEX = 0;
  localparam int EV_SPEED  = 1;
  localparam int EV_LINK   = 2;
  localparam int EV_ARB    = 3;

  localparam logic [4:0] ADDR_DEFAULT = 5'h01;

  typedef enum logic [2:0] {
    ST_FORCED   = 3'b000,
    ST_ABILITY  = 3'b001,
    ST_LINK_OK  = 3'b010,
    ST_PARALLEL = 3'b011,
    ST_FAIL     = 3'b100
  } pamc_arb_e;

  // Events seen on the line by the analog front end
  typedef struct packed {
    logic       nlpRx;        // Normal link pulse received
    logic       idle100Rx;    // 100 Mbps active idle received
    logic       flpRx;        // Partner ability word received
    logic [3:0] partnerAbil;  // Partner abilities with flpRx
    logic       linkPulse;    // Any valid link activity keeping link alive
    logic       rxEnergy;     // Signal present on the receive pair
    logic       txAct;
    logic       rxAct;
    logic       collision;
  } pamc_line_s;

  // Levels on the strap pins
  typedef struct packed {
    logic       negotiationEnable;
    logic       duplex;
    logic       speed;
    logic       repeater;
    logic       ledMode2;     // Pull-up on carrier sense
    logic [4:0] stationAddr;  // From the indicator pins
  } pamc_strap_s;

  // Mode outputs toward the data path and analog front end
  typedef struct packed {
    logic flpTx;
    logic mdixSwap;
    logic linkUp;
    logic speed100;
    logic fullDuplex;
    logic pause;
    logic powerDown;
    logic autoPowerSaving;
    logic analogOff;
    logic macIsolate;
    logic repeaterMode;
  } pamc_mode_s;
endpackage
`default_nettype wire

// *** rtl/pamc_top.sv ***
// Purpose: Negotiation, strap decode, crossover, indicators, power and interrupt control of a 10/100 PHY
// Assumes: Line events arrive decoded and synchronous; register port answers one cycle after a read
// Notes:   All state is one struct; timers above 4096 cycles are parameters for short simulations
//
// Design decisions made here: the register addresses and the plain strobed port.
`default_nettype none
module pamc_top #(
  parameter int LINK_FAIL_CYC = pamc_pkg::LINK_FAIL_MS * pamc_pkg::CLK_KHZ,
  parameter int HW_RST_CYC    = pamc_pkg::HW_RST_MS * pamc_pkg::CLK_KHZ,
  parameter int XOVER_CYC     = pamc_pkg::XOVER_MS * pamc_pkg::CLK_KHZ,
  parameter int BLINK_CYC     = pamc_pkg::BLINK_MS * pamc_pkg::CLK_KHZ
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  hwResetN,
  input  wire pamc_pkg::pamc_strap_s strap,
  input  wire logic                  isolateInput,
  input  wire pamc_pkg::pamc_line_s  line,
  input  wire logic [4:0]            regAddr,
  input  wire logic [15:0]           regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output var  logic [15:0]           regRdata,
  output var  pamc_pkg::pamc_mode_s  mode,
  output var  logic [4:0]            indicator,
  output var  logic [4:0]            stationAddr,
  output var  logic                  carrierSense,
  output var  logic                  intN
);

  typedef struct packed {
    pamc_pkg::pamc_strap_s strapHeld;
    logic                  strapsDue;
    logic                  anEn;
    logic                  spdSel;
    logic                  dupSel;
    logic                  pwrDown;
    logic [3:0]            adv;
    logic                  pause;
    logic                  xoverOff;
    logic                  rptrBit;
    logic                  auto_power_saving;
    logic                  anaOff;
    logic [3:0]            intMask;
    logic [3:0]            intFlag;
    pamc_pkg::pamc_arb_e   arb;
    logic                  linkUp;
    logic                  speed100;
    logic                  fullDup;
    logic                  mdixSwap;
    logic [27:0]           linkTmr;
    logic [27:0]           xoverTmr;
    logic [27:0]           blinkTmr;
    logic [27:0]           rstTmr;
    logic                  actPend;
    logic                  colPend;
    logic                  blinkOn;
    logic [15:0]           rdata;
    pamc_pkg::pamc_mode_s  modeOut;
    logic [4:0]            ledOut;
    logic                  crs;
    logic                  intNOut;
  } pamc_state_s;

  pamc_state_s stateFf;
  pamc_state_s nxtState;

  // Ability vector built from the straps
  function automatic logic [3:0] pamc_strap_abil(input logic dup, input logic speed_strap);
    logic [3:0] abil;
    abil = 4'h1;
    abil[1] = dup;
    abil[2] = speed_strap;
    abil[3] = dup & speed_strap;
    return abil;
  endfunction

  // Load every software-visible field with its default derived from the held straps
  function automatic pamc_state_s pamc_defaults(input pamc_state_s s, input pamc_pkg::pamc_strap_s st);
    pamc_state_s r;
    r = s;
    r.anEn     = st.negotiationEnable;
    r.spdSel   = st.speed;
    r.dupSel   = st.duplex;
    r.pwrDown  = 1'b0;
    r.adv      = pamc_strap_abil(st.duplex, st.speed);
    r.pause    = 1'b0;
    r.xoverOff = ~st.negotiationEnable;
    r.rptrBit  = 1'b0;
    r.auto_power_saving      = 1'b0;
    r.anaOff   = 1'b0;
    r.intMask  = 4'h0;
    r.intFlag  = 4'h0;
    r.arb      = st.negotiationEnable ? pamc_pkg::ST_ABILITY : pamc_pkg::ST_FORCED;
    r.linkUp   = 1'b0;
    r.linkTmr  = 28'h0000000;
    r.xoverTmr = 28'h0000000;
    r.mdixSwap = 1'b0;
    return r;
  endfunction

  logic [3:0]  common;
  logic        regOk;
  logic        hwRstDone;
  logic        tmrExpire;
  logic        blinkTick;
  logic [3:0]  events;

  always_comb begin
    nxtState = stateFf;
    events   = 4'h0;
    common   = stateFf.adv & line.partnerAbil;
    // Management access is cut while isolated
    regOk    = ~isolateInput;
    hwRstDone = (stateFf.rstTmr == 28'(HW_RST_CYC - 1)) & ~hwResetN;
    tmrExpire = (stateFf.linkTmr == 28'(LINK_FAIL_CYC - 1));
    blinkTick = (stateFf.blinkTmr == 28'(BLINK_CYC - 1));

    // Reset pin must stay low the whole window; a glitch restarts the count
    nxtState.rstTmr = hwResetN ? 28'h0000000 : (hwRstDone ? stateFf.rstTmr : stateFf.rstTmr + 28'h0000001);

    // Straps are taken once after power-on or a completed pin reset, then held; soft reset reuses the held straps
    if (stateFf.strapsDue) begin
      nxtState.strapHeld = strap;
      nxtState.strapsDue = 1'b0;
      nxtState = pamc_defaults(nxtState, strap);
    end else if (!stateFf.pwrDown) begin
      // Negotiation arbiter; frozen while powered down
      nxtState.linkTmr = stateFf.linkTmr + 28'h0000001;
      case (stateFf.arb)
        pamc_pkg::ST_FORCED: begin
          // Forced mode: no ability exchange, link on any partner activity
          nxtState.speed100 = stateFf.spdSel;
          nxtState.fullDup  = stateFf.dupSel;
          if (line.linkPulse) begin
            nxtState.linkUp  = 1'b1;
            nxtState.linkTmr = 28'h0000000;
          end else if (tmrExpire) begin
            nxtState.linkUp  = 1'b0;
            nxtState.linkTmr = 28'h0000000;
          end
        end
        pamc_pkg::ST_ABILITY: begin
          if (line.flpRx && common != 4'h0) begin
            nxtState.arb      = pamc_pkg::ST_LINK_OK;
            nxtState.speed100 = common[3] | common[2];
            nxtState.fullDup  = common[3] | (~common[2] & common[1]);
            nxtState.linkUp   = 1'b1;
            nxtState.linkTmr  = 28'h0000000;
          end else if (line.idle100Rx && stateFf.adv[2]) begin
            nxtState.arb      = pamc_pkg::ST_PARALLEL;
            nxtState.speed100 = 1'b1;
            nxtState.fullDup  = 1'b0;
            nxtState.linkUp   = 1'b1;
            nxtState.linkTmr  = 28'h0000000;
          end else if (line.nlpRx) begin
            nxtState.arb      = pamc_pkg::ST_PARALLEL;
            nxtState.speed100 = 1'b0;
            nxtState.fullDup  = 1'b0;
            nxtState.linkUp   = 1'b1;
            nxtState.linkTmr  = 28'h0000000;
          end else if (tmrExpire) begin
            nxtState.linkTmr  = 28'h0000000;
          end
        end
        pamc_pkg::ST_LINK_OK, pamc_pkg::ST_PARALLEL: begin
          if (line.linkPulse) begin
            nxtState.linkTmr = 28'h0000000;
          end else if (tmrExpire) begin
            nxtState.arb     = pamc_pkg::ST_FAIL;
            nxtState.linkUp  = 1'b0;
            nxtState.linkTmr = 28'h0000000;
          end
        end
        pamc_pkg::ST_FAIL: begin
          // One cycle in link fail, then negotiation starts over
          nxtState.arb = pamc_pkg::ST_ABILITY;
        end
        default: begin
          nxtState.arb = pamc_pkg::ST_FORCED;
        end
      endcase

      // Crossover hunts only while negotiating and not disabled by software
      if (stateFf.anEn && !stateFf.xoverOff && !stateFf.linkUp && !line.rxEnergy) begin
        if (stateFf.xoverTmr == 28'(XOVER_CYC - 1)) begin
          nxtState.mdixSwap = ~stateFf.mdixSwap;
          nxtState.xoverTmr = 28'h0000000;
        end else begin
          nxtState.xoverTmr = stateFf.xoverTmr + 28'h0000001;
        end
      end else begin
        nxtState.xoverTmr = 28'h0000000;
      end
      if (!stateFf.anEn || stateFf.xoverOff) begin
        nxtState.mdixSwap = 1'b0;
      end
    end

    // Register writes; control bits steer the arbiter directly
    if (regWr && regOk && !stateFf.strapsDue) begin
      case (regAddr)
        pamc_pkg::REG_CTRL: begin
          nxtState.spdSel  = regWdata[pamc_pkg::CTRL_SPEED];
          nxtState.dupSel  = regWdata[pamc_pkg::CTRL_DUPLEX];
          nxtState.anEn    = regWdata[pamc_pkg::CTRL_AN_EN];
          nxtState.pwrDown = regWdata[pamc_pkg::CTRL_PWR_DOWN];
          if (!regWdata[pamc_pkg::CTRL_AN_EN]) begin
            nxtState.arb    = pamc_pkg::ST_FORCED;
            nxtState.linkUp = 1'b0;
          end else if (regWdata[pamc_pkg::CTRL_RESTART] || !stateFf.anEn) begin
            nxtState.arb     = pamc_pkg::ST_ABILITY;
            nxtState.linkUp  = 1'b0;
            nxtState.linkTmr = 28'h0000000;
          end
          if (regWdata[pamc_pkg::CTRL_SOFT_RST]) begin
            nxtState = pamc_defaults(nxtState, stateFf.strapHeld);
          end
        end
        pamc_pkg::REG_ADV: begin
          nxtState.adv   = regWdata[pamc_pkg::ADV_ABIL_LSB +: 4];
          nxtState.pause = regWdata[pamc_pkg::ADV_PAUSE];
        end
        pamc_pkg::REG_SPEC: begin
          nxtState.xoverOff = regWdata[pamc_pkg::SPEC_XOVER_OFF];
          nxtState.rptrBit  = regWdata[pamc_pkg::SPEC_REPEATER];
          nxtState.auto_power_saving      = regWdata[pamc_pkg::SPEC_APS];
          nxtState.anaOff   = regWdata[pamc_pkg::SPEC_ANA_OFF];
        end
        pamc_pkg::REG_INT: begin
          nxtState.intMask = regWdata[pamc_pkg::INT_MASK_LSB +: 4];
        end
        default: begin
        end
      endcase
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    nxtState.rdata = 16'h0000;
    if (regRd && regOk) begin
      case (regAddr)
        pamc_pkg::REG_CTRL: begin
          nxtState.rdata[pamc_pkg::CTRL_SPEED]    = stateFf.spdSel;
          nxtState.rdata[pamc_pkg::CTRL_AN_EN]    = stateFf.anEn;
          nxtState.rdata[pamc_pkg::CTRL_PWR_DOWN] = stateFf.pwrDown;
          nxtState.rdata[pamc_pkg::CTRL_DUPLEX]   = stateFf.dupSel;
        end
        pamc_pkg::REG_ADV: begin
          nxtState.rdata[pamc_pkg::ADV_PAUSE]         = stateFf.pause;
          nxtState.rdata[pamc_pkg::ADV_ABIL_LSB +: 4] = stateFf.adv;
          nxtState.rdata[4:0]                         = pamc_pkg::ADV_SELECTOR;
        end
        pamc_pkg::REG_SPEC: begin
          nxtState.rdata[pamc_pkg::SPEC_XOVER_OFF] = stateFf.xoverOff;
          nxtState.rdata[pamc_pkg::SPEC_REPEATER]  = stateFf.rptrBit;
          nxtState.rdata[pamc_pkg::SPEC_APS]       = stateFf.auto_power_saving;
          nxtState.rdata[pamc_pkg::SPEC_ANA_OFF]   = stateFf.anaOff;
        end
        pamc_pkg::REG_INT: begin
          nxtState.rdata[pamc_pkg::INT_FLAG_LSB +: 4] = stateFf.intFlag;
          nxtState.rdata[pamc_pkg::INT_MASK_LSB +: 4] = stateFf.intMask;
          nxtState.intFlag = 4'h0;
        end
        default: begin
        end
      endcase
    end

    // Change events; a set in the cycle of a clearing read wins
    events[pamc_pkg::EV_DUPLEX] = nxtState.fullDup != stateFf.fullDup;
    events[pamc_pkg::EV_SPEED]  = nxtState.speed100 != stateFf.speed100;
    events[pamc_pkg::EV_LINK]   = nxtState.linkUp != stateFf.linkUp;
    events[pamc_pkg::EV_ARB]    = nxtState.arb != stateFf.arb;
    if (!stateFf.strapsDue) begin
      nxtState.intFlag = nxtState.intFlag | events;
    end
    nxtState.intNOut = ~|(nxtState.intFlag & nxtState.intMask);

    // Blink base and stretch: an event is held until the next tick shows it
    nxtState.blinkTmr = blinkTick ? 28'h0000000 : stateFf.blinkTmr + 28'h0000001;
    nxtState.actPend  = stateFf.actPend | line.txAct | line.rxAct;
    nxtState.colPend  = stateFf.colPend | line.collision;
    if (blinkTick) begin
      nxtState.blinkOn = (stateFf.actPend | stateFf.colPend) & ~stateFf.blinkOn;
      nxtState.actPend = line.txAct | line.rxAct;
      nxtState.colPend = line.collision;
    end

    // Indicator mapping; blinking drops the lamp during the off phase, but inverts the duplex lamp in the second mode
    if (!stateFf.strapHeld.ledMode2) begin
      nxtState.ledOut[0] = stateFf.linkUp;
      nxtState.ledOut[1] = stateFf.linkUp & stateFf.fullDup;
      nxtState.ledOut[2] = stateFf.linkUp & ~stateFf.speed100 & ~(stateFf.blinkOn & stateFf.actPend);
      nxtState.ledOut[3] = stateFf.linkUp & stateFf.speed100 & ~(stateFf.blinkOn & stateFf.actPend);
      nxtState.ledOut[4] = stateFf.colPend;
    end else begin
      nxtState.ledOut[0] = stateFf.linkUp & ~(stateFf.blinkOn & stateFf.actPend);
      nxtState.ledOut[1] = (stateFf.linkUp & stateFf.fullDup) ^ (stateFf.blinkOn & stateFf.colPend);
      nxtState.ledOut[2] = stateFf.linkUp & ~stateFf.speed100;
      nxtState.ledOut[3] = stateFf.linkUp & stateFf.speed100;
      nxtState.ledOut[4] = 1'b0;
    end

    // Carrier sense: receive only in repeater mode
    nxtState.crs = line.rxAct | (line.txAct & ~(stateFf.rptrBit | stateFf.strapHeld.repeater));

    // Mode outputs
    nxtState.modeOut.flpTx           = stateFf.arb == pamc_pkg::ST_ABILITY && !stateFf.pwrDown;
    nxtState.modeOut.mdixSwap        = stateFf.mdixSwap;
    nxtState.modeOut.linkUp          = stateFf.linkUp;
    nxtState.modeOut.speed100        = stateFf.speed100;
    nxtState.modeOut.fullDuplex      = stateFf.fullDup;
    nxtState.modeOut.pause           = stateFf.pause;
    nxtState.modeOut.powerDown       = stateFf.pwrDown;
    nxtState.modeOut.autoPowerSaving = stateFf.auto_power_saving;
    nxtState.modeOut.analogOff       = stateFf.anaOff;
    nxtState.modeOut.macIsolate      = isolateInput;
    nxtState.modeOut.repeaterMode    = stateFf.rptrBit | stateFf.strapHeld.repeater;

    // A completed pin reset behaves like power-on: straps are taken again
    if (hwRstDone) begin
      nxtState.strapsDue = 1'b1;
      nxtState.linkUp    = 1'b0;
    end
  end

  // Single state register; reset loads constants only
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateFf <= '0;
      stateFf.strapsDue <= 1'b1;
      stateFf.strapHeld.stationAddr <= pamc_pkg::ADDR_DEFAULT;
      stateFf.intNOut <= 1'b1;
    end else begin
      stateFf <= nxtState;
    end
  end

  assign regRdata     = stateFf.rdata;
  assign mode         = stateFf.modeOut;
  assign indicator    = stateFf.ledOut;
  assign stationAddr  = stateFf.strapHeld.stationAddr;
  assign carrierSense = stateFf.crs;
  assign intN         = stateFf.intNOut;

endmodule
`default_nettype wire

// *** verif/pamc_top_monitor.sv ***
// Purpose: Port checker for pamc_top
// Assumes: One clock domain, sys_rst async active high
// Notes:   Bound to every pamc_top instance
`default_nettype none
module pamc_top_monitor (
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  input wire logic                  hwResetN,
  input wire pamc_pkg::pamc_strap_s strap,
  input wire logic                  isolateInput,
  input wire pamc_pkg::pamc_line_s  line,
  input wire logic [4:0]            regAddr,
  input wire logic [15:0]           regWdata,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [15:0]           regRdata,
  input wire pamc_pkg::pamc_mode_s  mode,
  input wire logic [4:0]            indicator,
  input wire logic [4:0]            stationAddr,
  input wire logic                  carrierSense,
  input wire logic                  intN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] upCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Settle count after a power-on or pin reset, so the strap load edge is never judged
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) upCnt <= 3'h0;
    else if (!hwResetN) upCnt <= 3'h0;
    else if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
  end
  a_read_slot: assert property (!regRd || isolateInput |=> regRdata == 16'h0000)
    else $error("read data outside its slot");
  a_int_spare: assert property (regRd && !isolateInput && regAddr == pamc_pkg::REG_INT
    |=> regRdata[15:12] == 4'h0 && regRdata[7:4] == 4'h0) else $error("spare cause bits set");
  a_adv_select: assert property (regRd && !isolateInput && regAddr == pamc_pkg::REG_ADV
    |=> regRdata[4:0] == pamc_pkg::ADV_SELECTOR) else $error("selector field wrong");
  a_link_quiet: assert property (mode.linkUp |-> !mode.flpTx) else $error("bursts while linked");
  a_parallel_half: assert property (mode.flpTx && !mode.powerDown && line.nlpRx && !line.flpRx
    && !line.idle100Rx |-> ##2 mode.linkUp && !mode.fullDuplex && !mode.speed100) else $error("parallel link");
  a_repeater_rx: assert property (mode.repeaterMode && !line.rxAct ##1 mode.repeaterMode
    |-> !carrierSense) else $error("carrier on transmit in repeater");
  a_nic_tx: assert property (!mode.repeaterMode && line.txAct ##1 !mode.repeaterMode |-> carrierSense)
    else $error("no carrier on transmit");
  a_addr_held: assert property (upCnt == 3'h7 |-> $stable(stationAddr)) else $error("address moved");
  a_pd_freeze: assert property (mode.powerDown ##1 mode.powerDown |-> $stable(mode.linkUp))
    else $error("link moved in power down");
endmodule
bind pamc_top pamc_top_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .hwResetN(hwResetN),
  .strap(strap), .isolateInput(isolateInput), .line(line), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .mode(mode), .indicator(indicator),
  .stationAddr(stationAddr), .carrierSense(carrierSense), .intN(intN));
`default_nettype wire

// *** verif/pamc_link_partner.sv ***
// Purpose: Remote link partner seen through the front end
// Assumes: Pulse events one cycle wide, every eight cycles
// Notes:   kind 1 plain pulses, 2 fast idle, 3 ability bursts
`default_nettype none
module pamc_link_partner (
  input wire logic                 sys_clk,
  input wire logic                 alive,
  input wire logic [1:0]           kind,
  input wire logic [3:0]           abil,
  input wire logic [2:0]           act,
  output var pamc_pkg::pamc_line_s line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] gap = 3'h0;
  // A dead cable carries no pulses and no energy, so link timers run out
  always_ff @(posedge sys_clk) begin
    gap <= gap + 3'h1;
    line <= '0;
    line.rxEnergy <= alive;
    {line.txAct, line.rxAct, line.collision} <= act;
    if (alive && gap == 3'h0) begin
      line.linkPulse <= 1'b1;
      line.nlpRx <= kind == 2'h1;
      line.idle100Rx <= kind == 2'h2;
      line.flpRx <= kind == 2'h3;
      line.partnerAbil <= abil;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Directed test of pamc_top through its register port
// Assumes: Short timer parameters, partner model on the line side
// Notes:   All waits bounded; a spent bound ends the run
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, hwResetN = 1'b1, isolateInput = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, alive = 1'b0, carrierSense, intN;
  logic [4:0] regAddr = 5'h00, indicator, stationAddr;
  logic [15:0] regWdata = 16'h0000, regRdata, v;
  logic [1:0] kind = 2'h3;
  logic [2:0] act = 3'h0;
  pamc_pkg::pamc_strap_s strap = 10'h38A;
  pamc_pkg::pamc_line_s line;
  pamc_pkg::pamc_mode_s mode;
  int errors = 0, tests_run = 0, k;
  // Free running 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  pamc_top #(.LINK_FAIL_CYC(50), .HW_RST_CYC(10), .XOVER_CYC(20), .BLINK_CYC(8)) DUT (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .hwResetN(hwResetN), .strap(strap), .isolateInput(isolateInput), .line(line),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .mode(mode), .indicator(indicator), .stationAddr(stationAddr), .carrierSense(carrierSense), .intN(intN));
  pamc_link_partner u_peer (.sys_clk(sys_clk), .alive(alive), .kind(kind), .abil(4'hF), .act(act), .line(line));
  task final_report;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A spent wait bound counts as a mismatch and stops the run
  task bnd;
    if (k >= 200) begin
      errors++;
      final_report();
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [4:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    // Taken at the edge that closes the data cycle, before the slot clears
    @(posedge sys_clk) v = regRdata;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    chk(16'(stationAddr), 16'h0001);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(16'(stationAddr), 16'h000A);
    chk(16'(mode.flpTx), 16'h0001);
    rd(pamc_pkg::REG_ADV);
    chk(v, 16'h01E1);
    wr(pamc_pkg::REG_ADV, 16'h05E1);
    rd(pamc_pkg::REG_ADV);
    chk(v, 16'h05E1);
    chk(16'(mode.pause), 16'h0001);
    wr(pamc_pkg::REG_INT, 16'h0400);
    alive <= 1'b1;
    for (k = 0; k < 200 && !mode.linkUp; k++) @(posedge sys_clk);
    bnd();
    repeat (2) @(posedge sys_clk);
    chk(16'({mode.speed100, mode.fullDuplex, indicator, intN}), 16'h00D6);
    rd(pamc_pkg::REG_INT);
    chk(v & 16'h0F04, 16'h0404);
    rd(pamc_pkg::REG_INT);
    chk(v & 16'h0004, 16'h0000);
    repeat (2) @(posedge sys_clk);
    chk(16'(intN), 16'h0001);
    alive <= 1'b0;
    wr(pamc_pkg::REG_CTRL, 16'h3300);
    repeat (4) @(posedge sys_clk);
    chk(16'(mode.flpTx), 16'h0001);
    kind <= 2'h1;
    alive <= 1'b1;
    for (k = 0; k < 200 && !mode.linkUp; k++) @(posedge sys_clk);
    bnd();
    chk(16'({mode.speed100, mode.fullDuplex}), 16'h0000);
    alive <= 1'b0;
    for (k = 0; k < 200 && mode.linkUp; k++) @(posedge sys_clk);
    bnd();
    chk(16'(k > 40 && k < 60), 16'h0001);
    kind <= 2'h2;
    alive <= 1'b1;
    for (k = 0; k < 200 && !mode.linkUp; k++) @(posedge sys_clk);
    bnd();
    chk(16'({mode.speed100, mode.fullDuplex}), 16'h0002);
    wr(pamc_pkg::REG_SPEC, 16'h0007);
    act <= 3'h4;
    repeat (3) @(posedge sys_clk);
    chk(16'({mode.repeaterMode, mode.autoPowerSaving, mode.analogOff, carrierSense}),
      16'h000E);
    act <= 3'h2;
    repeat (3) @(posedge sys_clk);
    chk(16'(carrierSense), 16'h0001);
    // Steady receive activity must blink the 100M lamp off within a few ticks
    for (k = 0; k < 200 && indicator[3]; k++) @(posedge sys_clk);
    bnd();
    chk(16'(indicator[3:2]), 16'h0000);
    act <= 3'h0;
    wr(pamc_pkg::REG_CTRL, 16'h0800);
    rd(pamc_pkg::REG_SPEC);
    chk({v[15:1], mode.powerDown}, 16'h0007);
    isolateInput <= 1'b1;
    rd(pamc_pkg::REG_SPEC);
    chk({v[15:1], mode.macIsolate}, 16'h0001);
    isolateInput <= 1'b0;
    wr(pamc_pkg::REG_CTRL, 16'h8000);
    rd(pamc_pkg::REG_ADV);
    chk(v, 16'h01E1);
    alive <= 1'b0;
    strap <= 10'h13F;
    hwResetN <= 1'b0;
    repeat (12) @(posedge sys_clk);
    hwResetN <= 1'b1;
    alive <= 1'b1;
    for (k = 0; k < 200 && !mode.linkUp; k++) @(posedge sys_clk);
    bnd();
    repeat (2) @(posedge sys_clk);
    chk(16'({mode.flpTx, mode.speed100, mode.fullDuplex, indicator, stationAddr}), 16'h04FF);
    // Outside repeater mode transmit alone raises carrier sense
    act <= 3'h4;
    repeat (3) @(posedge sys_clk);
    chk(16'(carrierSense), 16'h0001);
    act <= 3'h0;
    alive <= 1'b0;
    wr(pamc_pkg::REG_CTRL, 16'h1200);
    repeat (60) @(posedge sys_clk);
    chk(16'(mode.mdixSwap), 16'h0000);
    wr(pamc_pkg::REG_SPEC, 16'h0000);
    for (k = 0; k < 200 && !mode.mdixSwap; k++) @(posedge sys_clk);
    bnd();
    chk(16'(mode.mdixSwap), 16'h0001);
    wr(pamc_pkg::REG_CTRL, 16'h0000);
    wr(pamc_pkg::REG_SPEC, 16'h0800);
    rd(pamc_pkg::REG_SPEC);
    chk(v, 16'h0800);
    chk(16'(mode.mdixSwap), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
